// ===== rtl/dma_ctrl_defs.svh
`ifndef DMA_CTRL_DEFS_SVH
`define DMA_CTRL_DEFS_SVH
// module-level word offsets (byte addresses)
`define OFS_MODULE_CONTROL 12'h000
`define OFS_UPPER_LIMIT 12'h004
`define OFS_LOWER_LIMIT 12'h008
`define OFS_DATA_BUFFER 12'h00C
// channel block: base + n * stride, five words each
`define OFS_CHAN_BASE 12'h040
`define CHAN_STRIDE 12'h020
`define OFS_CH_CONTROL 12'h000
`define OFS_CH_INTERRUPT 12'h004
`define OFS_CH_SOURCE 12'h008
`define OFS_CH_DEST 12'h00C
`define OFS_CH_COUNT 12'h010
// module control fields
`define MC_ENABLE_BIT 15
`define MC_PRIO_BIT 0
`define MC_WRITE_MASK 16'h8001
// channel control fields
`define CC_NULL_WRITE_MODE_BIT 10
`define CC_RELOAD_BIT 9
`define CC_SWREQ_BIT 8
`define CC_SOURCE_ADDRESS_MODE_HI 7
`define CC_SOURCE_ADDRESS_MODE_LO 6
`define CC_DESTINATION_ADDRESS_MODE_HI 5
`define CC_DESTINATION_ADDRESS_MODE_LO 4
`define CC_TRANSFER_MODE_FIELD_HI 3
`define CC_TRANSFER_MODE_FIELD_LO 2
`define CC_SIZE_BIT 1
`define CC_ENABLE_BIT 0
`define CC_WRITE_MASK 16'h07FF
`define INT_WRITE_MASK 16'h3FF9
`define REG_RESET 16'h0000
`endif

// ===== rtl/dma_ctrl_pkg.sv
package dma_ctrl_pkg;
  typedef enum logic [1:0]
  {
    addr_fixed,
    addr_inc,
    addr_dec,
    addr_indirect
  } addr_mode_t;
  typedef enum logic [1:0]
  {
    tr_one_shot,
    tr_rep_one_shot,
    tr_continuous,
    tr_rep_continuous
  } tr_mode_t;
  typedef enum
  {
    st_idle,
    st_read,
    st_write,
    st_null
  } xfer_state_t;
endpackage : dma_ctrl_pkg

// ===== rtl/dma_channel_control_regs.sv
// Function
// RULE1: clearing module enable aborts all channels
// RULE2: priority select: one round-robin, zero fixed
// RULE3: null-write adds dummy source write per transfer
// RULE4: reload restores pointers and count on start; code restores them as the last transfer completes
// RULE5: software request starts transfer, self-clears
// RULE6: source mode: indirect, dec, inc, fixed; code leaves an indirect pointer unchanged, as in fixed
// RULE7: destination mode uses same encoding
// RULE8: transfer mode: one-shot, continuous, repeated forms
// RULE9: size bit: one byte, zero word
// RULE10: disabled channel performs no transfers
// RULE11: software writes zero to reserved bit
// RULE12: unimplemented bits ignore writes, read zero
// RULE13: four module-level registers
// RULE14: five registers per channel
// RULE15: only original count stored for reload
// RULE16: repeated modes always reload count
// RULE17: request transfer count follows transfer mode
// RULE18: one-shot single, continuous count transactions
// RULE19: fixed priority: lowest channel wins
// RULE20: step one for bytes, two for words
// RULE21: control bits reset to zero
//
// Design decisions made here: the address map and register access over APB.
`include "dma_ctrl_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module dma_channel_control_regs
  import dma_ctrl_pkg::*;
#(
  parameter int NUM_CH = 6
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_CH-1:0] trigger_in,
  output logic bus_req,
  output logic bus_write,
  output logic [15:0] bus_addr,
  output logic [15:0] bus_wdata,
  output logic bus_byte,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_ack,
  output logic [NUM_CH-1:0] done_pulse
);
  if (NUM_CH < 1 || NUM_CH > 6)
    $error("NUM_CH must be 1 to 6");

  // ==================================================
  // register storage
  logic [15:0] mctl_q;
  logic [15:0] upper_q;
  logic [15:0] lower_q;
  logic [15:0] buf_q;
  logic [15:0] cctl_q [NUM_CH];
  logic [15:0] cint_q [NUM_CH];
  logic [15:0] src_q [NUM_CH];
  logic [15:0] dst_q [NUM_CH];
  logic [15:0] cnt_q [NUM_CH];
  // original count; pointers are rebuilt from it
  logic [15:0] cnt0_q [NUM_CH];
  logic [NUM_CH-1:0] pend_q;
  logic [NUM_CH-1:0] trig_s1_q;
  logic [NUM_CH-1:0] trig_s2_q;
  logic [NUM_CH-1:0] trig_d_q;
  xfer_state_t state_q;
  logic [2:0] cur_q;
  logic [2:0] last_q;
  logic [15:0] data_q;

  // ==================================================
  // apb decode
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  wire logic in_ch = paddr >= `OFS_CHAN_BASE;
  wire logic [11:0] crel = paddr - `OFS_CHAN_BASE;
  wire logic [2:0] dch = crel[7:5];
  wire logic [11:0] dwd = {7'h00, crel[4:0]};
  wire logic ch_ok = in_ch && !(|crel[11:8]) && ({1'b0, dch} < 4'(NUM_CH))
    && (dwd <= `OFS_CH_COUNT) && (paddr[1:0] == 2'b00);
  wire logic mod_ok = !in_ch && (paddr <= `OFS_DATA_BUFFER)
    && (paddr[1:0] == 2'b00);
  wire logic mapped = ch_ok || mod_ok;
  wire logic lo_wr = wr && (&pstrb[1:0]);
  wire logic [15:0] wd = pwdata[15:0];
  wire logic mod_en = mctl_q[`MC_ENABLE_BIT];

  logic [15:0] rd_val;
  always_comb
  begin
    rd_val = 16'h0000;
    if (mod_ok)
      case (paddr)
        `OFS_MODULE_CONTROL: rd_val = mctl_q;
        `OFS_UPPER_LIMIT: rd_val = upper_q;
        `OFS_LOWER_LIMIT: rd_val = lower_q;
        `OFS_DATA_BUFFER: rd_val = buf_q;
        default: rd_val = 16'h0000;
      endcase
    else if (ch_ok)
      case (dwd)
        `OFS_CH_CONTROL: rd_val = cctl_q[dch];
        `OFS_CH_INTERRUPT: rd_val = cint_q[dch];
        `OFS_CH_SOURCE: rd_val = src_q[dch];
        `OFS_CH_DEST: rd_val = dst_q[dch];
        `OFS_CH_COUNT: rd_val = cnt_q[dch];
        default: rd_val = 16'h0000;
      endcase
  end

  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= {16'h0000, rd_val};
  end

  // ==================================================
  // trigger sync and arbitration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_s1_q <= '0;
      trig_s2_q <= '0;
      trig_d_q <= '0;
    end
    else
    begin
      trig_s1_q <= trigger_in;
      trig_s2_q <= trig_s1_q;
      trig_d_q <= trig_s2_q;
    end
  end

  logic [NUM_CH-1:0] ready_ch;
  logic [NUM_CH-1:0] swreq;
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_ready
      assign swreq[g] = cctl_q[g][`CC_SWREQ_BIT];
      // RULE10 RULE1: only enabled channels
      assign ready_ch[g] = mod_en && cctl_q[g][`CC_ENABLE_BIT]
        && (pend_q[g] || swreq[g]);
    end
  endgenerate

  // RULE2 RULE19: pick winner
  logic [2:0] win;
  logic found;
  always_comb
  begin
    win = 3'd0;
    found = 1'b0;
    for (int k = NUM_CH - 1; k >= 0; k--)
      if (ready_ch[k])
      begin
        win = 3'(k);
        found = 1'b1;
      end
    // round robin: first requester above the last winner
    if (mctl_q[`MC_PRIO_BIT])
      for (int k = NUM_CH - 1; k >= 0; k--)
        if (ready_ch[k] && 3'(k) > last_q)
          win = 3'(k);
  end

  // ==================================================
  // transfer engine
  wire logic [15:0] c_ctl = cctl_q[cur_q];
  // RULE9: byte or word
  wire logic c_byte = c_ctl[`CC_SIZE_BIT];
  wire addr_mode_t c_sam =
    addr_mode_t'(c_ctl[`CC_SOURCE_ADDRESS_MODE_HI:`CC_SOURCE_ADDRESS_MODE_LO]);
  wire addr_mode_t c_dam =
    addr_mode_t'(c_ctl[`CC_DESTINATION_ADDRESS_MODE_HI:`CC_DESTINATION_ADDRESS_MODE_LO]);
  wire tr_mode_t c_tr =
    tr_mode_t'(c_ctl[`CC_TRANSFER_MODE_FIELD_HI:`CC_TRANSFER_MODE_FIELD_LO]);
  // RULE20: step size
  wire logic [15:0] step = c_byte ? 16'h0001 : 16'h0002;

  function automatic logic [15:0] next_ptr(input logic [15:0] p,
    input addr_mode_t m, input logic [15:0] s);
    case (m)
      // RULE6 RULE7: pointer update
      addr_inc: next_ptr = p + s;
      addr_dec: next_ptr = p - s;
      default: next_ptr = p;
    endcase
  endfunction : next_ptr

  // RULE15: rebuild origin from transfers done
  function automatic logic [15:0] orig_ptr(input logic [15:0] p,
    input addr_mode_t m, input logic [15:0] done, input logic b);
    logic [15:0] off;
    off = b ? done : 16'(done << 1);
    case (m)
      addr_inc: orig_ptr = p - off;
      addr_dec: orig_ptr = p + off;
      default: orig_ptr = p;
    endcase
  endfunction : orig_ptr

  wire logic [15:0] cnt_dec = cnt_q[cur_q] - 16'h0001;
  wire logic last_xfer = cnt_dec == 16'h0000;
  // RULE8: transfer mode decode
  wire logic contin = c_tr == tr_continuous || c_tr == tr_rep_continuous;
  wire logic repeated = c_tr == tr_rep_one_shot
    || c_tr == tr_rep_continuous;
  // RULE18: continuous keeps going within one trigger
  wire logic run_on = contin && !last_xfer;
  wire logic xfer_done = bus_ack && ((state_q == st_write
    && !c_ctl[`CC_NULL_WRITE_MODE_BIT]) || state_q == st_null);
  wire logic busy = state_q != st_idle;
  wire logic abort = !mod_en || !c_ctl[`CC_ENABLE_BIT];
  // RULE4 RULE16: reload when wrapping
  wire logic do_reload = last_xfer
    && (repeated || c_ctl[`CC_RELOAD_BIT]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= st_idle;
      cur_q <= 3'd0;
      last_q <= 3'd7;
      data_q <= 16'h0000;
    end
    // RULE1: terminate on disable
    else if (busy && abort)
      state_q <= st_idle;
    else
      case (state_q)
        st_idle:
          if (found)
          begin
            cur_q <= win;
            last_q <= win;
            state_q <= st_read;
          end
        st_read:
          if (bus_ack)
          begin
            data_q <= bus_rdata;
            state_q <= st_write;
          end
        // RULE3: dummy write after destination write
        st_write:
          if (bus_ack)
            state_q <= c_ctl[`CC_NULL_WRITE_MODE_BIT] ? st_null
              : (run_on ? st_read : st_idle);
        st_null:
          if (bus_ack)
            state_q <= run_on ? st_read : st_idle;
        default: state_q <= st_idle;
      endcase
  end

  assign bus_req = busy && !abort;
  assign bus_write = state_q == st_write || state_q == st_null;
  assign bus_byte = c_byte;
  assign bus_wdata = data_q;
  assign bus_addr = (state_q == st_write) ? dst_q[cur_q] : src_q[cur_q];

  // ==================================================
  // per-channel registers
  // RULE14: five registers each
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : g_chan
      wire logic sel = ch_ok && dch == 3'(g) && lo_wr;
      wire logic mine = xfer_done && cur_q == 3'(g) && !abort;
      wire logic trig = trig_s2_q[g] && !trig_d_q[g];
      wire logic [15:0] ndone = cnt0_q[g] - cnt_q[g];
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          // RULE21: all disabled
          cctl_q[g] <= `REG_RESET;
          cint_q[g] <= `REG_RESET;
          src_q[g] <= `REG_RESET;
          dst_q[g] <= `REG_RESET;
          cnt_q[g] <= `REG_RESET;
          cnt0_q[g] <= `REG_RESET;
          pend_q[g] <= 1'b0;
          done_pulse[g] <= 1'b0;
        end
        else
        begin
          done_pulse[g] <= mine && (!contin || last_xfer);
          // trigger wins over consumption in the same cycle
          if (trig)
            pend_q[g] <= 1'b1;
          else if (state_q == st_idle && found && win == 3'(g))
            pend_q[g] <= 1'b0;
          // RULE12 RULE11: masked write
          if (sel && dwd == `OFS_CH_CONTROL)
            cctl_q[g] <= wd & `CC_WRITE_MASK;
          // RULE5 RULE17: clear request when trigger's work ends
          else if (mine && (!contin || last_xfer))
            cctl_q[g][`CC_SWREQ_BIT] <= 1'b0;
          if (sel && dwd == `OFS_CH_INTERRUPT)
            cint_q[g] <= wd & `INT_WRITE_MASK;
          if (sel && dwd == `OFS_CH_SOURCE)
            src_q[g] <= wd;
          else if (mine)
            src_q[g] <= do_reload
              ? orig_ptr(src_q[g], c_sam, ndone, c_byte)
              : next_ptr(src_q[g], c_sam, step);
          if (sel && dwd == `OFS_CH_DEST)
            dst_q[g] <= wd;
          else if (mine)
            dst_q[g] <= do_reload
              ? orig_ptr(dst_q[g], c_dam, ndone, c_byte)
              : next_ptr(dst_q[g], c_dam, step);
          if (sel && dwd == `OFS_CH_COUNT)
          begin
            cnt_q[g] <= wd;
            cnt0_q[g] <= wd;
          end
          else if (mine)
            cnt_q[g] <= do_reload ? cnt0_q[g] : cnt_dec;
        end
      end
    end
  endgenerate

  // ==================================================
  // module-level registers
  // RULE13: control, two limits, data buffer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mctl_q <= `REG_RESET;
      upper_q <= `REG_RESET;
      lower_q <= `REG_RESET;
      buf_q <= `REG_RESET;
    end
    else
    begin
      // RULE12: only enable and priority bits stored
      if (mod_ok && lo_wr && paddr == `OFS_MODULE_CONTROL)
        mctl_q <= wd & `MC_WRITE_MASK;
      if (mod_ok && lo_wr && paddr == `OFS_UPPER_LIMIT)
        upper_q <= wd;
      if (mod_ok && lo_wr && paddr == `OFS_LOWER_LIMIT)
        lower_q <= wd;
      if (mod_ok && lo_wr && paddr == `OFS_DATA_BUFFER)
        buf_q <= wd;
      else if (state_q == st_read && bus_ack)
        buf_q <= bus_rdata;
    end
  end
endmodule : dma_channel_control_regs
`default_nettype wire

// ===== tb/dma_ctrl_sva.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// checker
module dma_ctrl_sva
#(
  parameter int NUM_CH = 6
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic [15:0] bus_rdata,
  input wire logic bus_ack,
  input wire logic [NUM_CH-1:0] done_pulse
);
  logic en_q;
  wire mc_wr = psel && penable && pwrite && paddr == 12'h000;
  // a write to the enable may abort the engine, so holds skip it
  wire busy = bus_req && en_q && !mc_wr;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      en_q <= 1'b0;
    else if (mc_wr && pstrb[1:0] == 2'h3)
      en_q <= pwdata[15];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_unmapped_err: assert property (
    psel && penable && paddr == 12'h014 |-> pslverr)
    else $error("no error on unmapped address");
  a_mapped_ok: assert property (
    psel && penable && paddr == 12'h040 |-> !pslverr)
    else $error("error on mapped address");
  a_upper_zero: assert property (prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_off_no_req: assert property (!en_q [*3] |-> !bus_req)
    else $error("bus request while disabled");
  a_read_then_write: assert property (
    busy && !bus_write && bus_ack
    |=> bus_req && bus_write && bus_wdata == $past(bus_rdata))
    else $error("write does not follow read");
  a_req_hold: assert property (
    busy && !bus_ack |=> bus_req && $stable(bus_addr) && $stable(bus_write))
    else $error("bus request not held");
  a_done_single: assert property (
    |done_pulse |=> (done_pulse & $past(done_pulse)) == '0)
    else $error("done pulse too long");
  c_write: cover property (bus_req && bus_write && bus_ack);
  c_done: cover property (|done_pulse);
  c_abort: cover property ($fell(en_q) ##1 !bus_req);
endmodule : dma_ctrl_sva

bind dma_channel_control_regs dma_ctrl_sva #(.NUM_CH(NUM_CH)) i_dma_ctrl_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_req(bus_req),
  .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_rdata(bus_rdata), .bus_ack(bus_ack), .done_pulse(done_pulse));
`default_nettype wire

// ===== tb/dma_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// data bus responder
module dma_bus_model
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bus_req,
  input wire logic [15:0] bus_addr,
  output logic [15:0] bus_rdata,
  output logic bus_ack
);
  int seed = 40;
  logic [1:0] wait_q;
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      bus_ack <= 1'b0;
      bus_rdata <= 16'h0000;
      wait_q <= 2'h0;
    end
    else if (bus_req === 1'b1 && !bus_ack && wait_q == 2'h0)
    begin
      // data is a function of the address so the bench can predict it
      bus_ack <= 1'b1;
      bus_rdata <= bus_addr ^ 16'hA5A5;
      wait_q <= 2'($random(seed));
    end
    else
    begin
      bus_ack <= 1'b0;
      // stale data must not look valid
      bus_rdata <= ~bus_rdata;
      if (wait_q != 2'h0)
        wait_q <= wait_q - 2'h1;
    end
endmodule : dma_bus_model
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
// ====
// bench
module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic watch = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'hF;
  logic [5:0] trigger_in = 6'h00;
  logic pready, pslverr, bus_req, bus_write, bus_byte, bus_ack;
  logic [31:0] prdata;
  logic [15:0] bus_addr, bus_wdata, bus_rdata, es, ed;
  logic [5:0] done_pulse;
  logic [31:0] rd_q[$];
  logic [31:0] wr_q[$];
  logic by_q[$];
  int fails = 0;
  int n_tests = 0;
  int seed = 40;
  always #2.5 pclk = ~pclk;
  dma_channel_control_regs i_dma_channel_control_regs (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_in(trigger_in),
    .bus_req(bus_req), .bus_write(bus_write), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_byte(bus_byte), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack), .done_pulse(done_pulse));
  dma_bus_model i_dma_bus_model (.pclk(pclk), .presetn(presetn),
    .bus_req(bus_req), .bus_addr(bus_addr), .bus_rdata(bus_rdata),
    .bus_ack(bus_ack));
  task automatic chk(input string w, input logic [31:0] e, s);
    n_tests++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", w, e, s);
    end
  endtask : chk
  task automatic complete_run(input logic hang);
    if (hang)
      fails++;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  always @(posedge pclk)
  begin
    if ((psel & penable & pready & !pwrite) === 1'b1 && rd_q.size() > 0)
      chk("read data", rd_q.pop_front(), prdata);
    if ((watch & bus_req & bus_write & bus_ack) === 1'b1)
    begin
      chk("bus write", wr_q.size() ? wr_q.pop_front() : 32'hXXXXXXXX,
          {bus_addr, bus_wdata});
      chk("bus size", {31'h00000000, by_q.size() ? by_q.pop_front() : 1'bX},
          {31'h00000000, bus_byte});
    end
  end
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1)
      complete_run(1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h00000000);
  endtask : rd
  function automatic logic [15:0] step(input logic [15:0] p,
                                       input logic [1:0] m, input logic b);
    return m == 2'h1 ? p + (b ? 16'h0001 : 16'h0002) :
           m == 2'h2 ? p - (b ? 16'h0001 : 16'h0002) : p;
  endfunction : step
  task automatic cfg(input int ch, input logic [15:0] c, s, d, n);
    logic [11:0] b;
    b = 12'h040 + 12'(ch * 32);
    apb(1'b1, b + 12'h008, {16'h0000, s});
    apb(1'b1, b + 12'h00C, {16'h0000, d});
    apb(1'b1, b + 12'h010, {16'h0000, n});
    for (int i = 0; i < (c[3] ? int'(n) : 1); i++)
    begin
      wr_q.push_back({d, s ^ 16'hA5A5});
      by_q.push_back(c[1]);
      if (c[10])
      begin
        wr_q.push_back({s, s ^ 16'hA5A5});
        by_q.push_back(c[1]);
      end
      s = step(s, c[7:6], c[1]);
      d = step(d, c[5:4], c[1]);
    end
    es = s;
    ed = d;
  endtask : cfg
  task automatic wait_done(input logic [5:0] m);
    int k;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while ((done_pulse & m) === 6'h00 && k < 3000);
    if ((done_pulse & m) === 6'h00)
      complete_run(1'b1);
  endtask : wait_done
  initial
  begin
    logic [31:0] r;
    logic [15:0] c;
    logic [11:0] b;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(12'h000, 32'h00000000);
    rd(12'h040, 32'h00000000);
    rd(12'h014, 32'h00000000);
    apb(1'b1, 12'h000, 32'hFFFFFFFF);
    rd(12'h000, 32'h00008001);
    apb(1'b1, 12'h060, 32'h0000EEFE);
    rd(12'h060, 32'h000006FE);
    apb(1'b1, 12'h060, 32'h00000000);
    apb(1'b1, 12'h000, 32'h00008000);
    $display("test registers done");
    for (int i = 0; i < 8; i++)
    begin
      r = $random(seed);
      c = {5'h00, i[0] ^ i[2], 2'b01, i[1:0], 2'(i + 1), i[2], 1'b0,
           r[14], 1'b1};
      b = 12'h040 + 12'(i % 6 * 32);
      cfg(i % 6, c, {4'h2, r[11:1], 1'b0}, {4'h6, r[27:17], 1'b0},
          16'(r[13:12]) + 16'h0001);
      apb(1'b1, b, {16'h0000, c});
      wait_done(6'(1 << (i % 6)));
      rd(b, {16'h0000, c & 16'hFEFF});
      rd(b + 12'h008, {16'h0000, es});
      rd(b + 12'h00C, {16'h0000, ed});
    end
    $display("test modes done");
    cfg(0, 16'h0015, 16'h3100, 16'h7100, 16'h0001);
    cfg(1, 16'h0011, 16'h3000, 16'h7000, 16'h0001);
    apb(1'b1, 12'h040, 32'h00000015);
    apb(1'b1, 12'h060, 32'h00000011);
    trigger_in <= 6'h03;
    repeat (2) @(posedge pclk);
    trigger_in <= 6'h00;
    wait_done(6'h01);
    wait_done(6'h02);
    apb(1'b1, 12'h000, 32'h00008001);
    cfg(2, 16'h0011, 16'h3400, 16'h7400, 16'h0001);
    cfg(0, 16'h0011, 16'h3300, 16'h7300, 16'h0001);
    apb(1'b1, 12'h080, 32'h00000011);
    apb(1'b1, 12'h040, 32'h00000011);
    trigger_in <= 6'h05;
    repeat (2) @(posedge pclk);
    trigger_in <= 6'h00;
    wait_done(6'h04);
    wait_done(6'h01);
    $display("test collision done");
    for (int i = 0; i < 2; i++)
    begin
      c = i ? 16'h016D : 16'h0369;
      cfg(3, c, 16'h3200, 16'h7200, 16'h0003);
      apb(1'b1, 12'h0A0, {16'h0000, c});
      wait_done(6'h08);
      rd(12'h0A8, 32'h00003200);
      rd(12'h0AC, 32'h00007200);
      rd(12'h0B0, 32'h00000003);
    end
    apb(1'b1, 12'h0C0, 32'h00000100);
    repeat (20) @(posedge pclk);
    rd(12'h0C0, 32'h00000100);
    chk("pending writes", 32'h00000000, 32'(wr_q.size()));
    $display("test reload done");
    watch <= 1'b0;
    cfg(2, 16'h0159, 16'h3000, 16'h7000, 16'h00C8);
    apb(1'b1, 12'h080, 32'h00000159);
    repeat (10) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h00000000);
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    chk("bus request", 32'h00000000, {31'h00000000, bus_req});
    $display("test abort done");
    complete_run(1'b0);
  end
endmodule : tb_top
`default_nettype wire
